// ---- bdma_defs.vh ----
// Constants for the banked data memory addressing block
// Summary of operation
// - Indirect port accesses go to the location held in the paired pointer.
// - Port zero reaches bank 0 only; port one reaches the selected bank.
// - Reading an indirect port itself returns 00H; writing it does nothing.
// - Both memory pointers are real, readable and writable registers.
// - Direct accesses always go to bank 0; bank 1 only via port one.
// - Reset clears the bank bit except watchdog reset in sleep or idle.
// - Bank register holds one bank bit at bit 0; bits 7 to 1 read zero.
// - ALU results land in the accumulator; no memory-to-memory move.
// - Writing program counter low jumps in page and inserts a dummy cycle.
// - Table read returns high byte to result register, low byte to target.
// - Mapping enables after 55H then AAH in consecutive instruction cycles.
// - While mapped, last page E0H to FFH reads option memory 00H to 1FH.
// - Unlock starts a slow oscillator timer; mapping ends after 4 periods.
// - Every new completed unlock restarts the mapping timer.
// - Unlock register is 8-bit read/write, reset zero, cleared on wake-up.
// - Special registers appear in all banks, except eeprom control at 40H.
// - Unused special register locations read 00H.
`ifndef BDMA_DEFS_VH
`define BDMA_DEFS_VH
`define BDMA_ADDR_IND0 8'h00
`define BDMA_ADDR_MP0 8'h01
`define BDMA_ADDR_IND1 8'h02
`define BDMA_ADDR_MP1 8'h03
`define BDMA_ADDR_BANK 8'h04
`define BDMA_ADDR_ACC 8'h05
`define BDMA_ADDR_PCL 8'h06
`define BDMA_ADDR_TABLE_POINTER_LOW 8'h07
`define BDMA_ADDR_TABLE_RESULT_HIGH 8'h08
`define BDMA_ADDR_TABLE_POINTER_HIGH 8'h09
`define BDMA_ADDR_UNLOCK 8'h3A
`define BDMA_ADDR_EECTL 8'h40
`define BDMA_SFR_TOP 8'h7F
`define BDMA_BANK_BIT 0
`define BDMA_RESET_BYTE 8'h00
`define BDMA_UNLOCK_KEY1 8'h55
`define BDMA_UNLOCK_KEY2 8'hAA
`define BDMA_OPT_PAGE_BASE 8'hE0
`define BDMA_MAP_PERIODS 3'h4
`endif

// ---- bdma_map_timer.v ----
// Option memory mapping window timer on slow oscillator ticks
`timescale 1ns/1ps
`include "bdma_defs.vh"
module bdma_map_timer
(
   clk,
   rst_n,
   oscPin,
   restart,
   mapActive
);
   input wire clk;
   input wire rst_n;
   input wire oscPin;
   input wire restart;
   output reg mapActive;
   reg sync1_q;
   reg sync2_q;
   reg sync3_q;
   reg oscLvl_q;
   reg [2:0] count_q;
   wire oscRise;
   // Rise counts once second and third stages agree
   assign oscRise = (sync2_q == sync3_q) && sync3_q && !oscLvl_q;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         oscLvl_q <= 1'b0;
         count_q <= 3'h0;
         mapActive <= 1'b0;
      end
      else
      begin
         sync1_q <= oscPin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q)
            oscLvl_q <= sync3_q;
         if (restart)
         begin
            count_q <= 3'h0;
            mapActive <= 1'b1;
         end
         else if (mapActive && oscRise)
         begin
            if (count_q == `BDMA_MAP_PERIODS - 3'h1)
               mapActive <= 1'b0;
            count_q <= count_q + 3'h1;
         end
      end
   end
endmodule

// ---- bdma_core.v ----
// Special register addressing, banking, table read and option mapping
`timescale 1ns/1ps
`include "bdma_defs.vh"
module bdma_core
#(
   parameter PC_WIDTH = 11,
   parameter OPT_WORDS = 32,
   parameter WORD_WIDTH = 16
)
(
   clk,
   rst_n,
   wdtSleepReset,
   wakeUp,
   lircClk,
   instrCycle,
   memRead,
   memWrite,
   memAddr,
   memWdata,
   memRdata,
   aluValid,
   aluResult,
   accumulator,
   ramEn,
   ramWe,
   ramAddr,
   ramWdata,
   ramRdata,
   sfrOtherHit,
   sfrOtherRdata,
   pcLoad,
   pcLoadValue,
   pcCurrent,
   dummyCycle,
   tableReq,
   tableLastPage,
   tableAddr,
   progRdata,
   tableLowData,
   tableDone,
   optWe,
   optWaddr,
   optWdata,
   mapActive
);
   input wire clk;
   input wire rst_n;
   input wire wdtSleepReset;
   input wire wakeUp;
   input wire lircClk;
   input wire instrCycle;
   input wire memRead;
   input wire memWrite;
   input wire [7:0] memAddr;
   input wire [7:0] memWdata;
   output reg [7:0] memRdata;
   input wire aluValid;
   input wire [7:0] aluResult;
   output reg [7:0] accumulator;
   output reg ramEn;
   output reg ramWe;
   output reg [8:0] ramAddr;
   output reg [7:0] ramWdata;
   input wire [7:0] ramRdata;
   input wire sfrOtherHit;
   input wire [7:0] sfrOtherRdata;
   output reg pcLoad;
   output reg [PC_WIDTH-1:0] pcLoadValue;
   input wire [PC_WIDTH-1:0] pcCurrent;
   output reg dummyCycle;
   input wire tableReq;
   input wire tableLastPage;
   output wire [PC_WIDTH-1:0] tableAddr;
   input wire [WORD_WIDTH-1:0] progRdata;
   output reg [7:0] tableLowData;
   output reg tableDone;
   input wire optWe;
   input wire [4:0] optWaddr;
   input wire [WORD_WIDTH-1:0] optWdata;
   output wire mapActive;

   localparam ST_IDLE = 2'b01;
   localparam ST_ARMED = 2'b10;

   reg [7:0] memPtrZero_q;
   reg [7:0] memPtrOne_q;
   reg bankSelectBit_q;
   reg [7:0] tablePtrLow_q;
   reg [7:0] tablePtrHigh_q;
   reg [7:0] tableResultHigh_q;
   reg [7:0] optionMapUnlock_q;
   reg [1:0] unlockState_q;
   reg unlockDone;
   reg [WORD_WIDTH-1:0] optMem [0:OPT_WORDS-1];
   reg [7:0] effAddr;
   reg effBank;
   reg isIndirect;
   reg isSfr;
   reg [7:0] sfrData;
   reg sfrKnown;
   wire [PC_WIDTH-1:0] lastPageBase;
   wire inOptWindow;
   wire [WORD_WIDTH-1:0] tableWord;

   // Address resolution for direct and indirect accesses
   always @*
   begin
      isIndirect = 1'b0;
      effAddr = memAddr;
      effBank = 1'b0;
      if (memAddr == `BDMA_ADDR_IND0)
      begin
         isIndirect = 1'b1;
         effAddr = memPtrZero_q;
         effBank = 1'b0;
      end
      else if (memAddr == `BDMA_ADDR_IND1)
      begin
         isIndirect = 1'b1;
         effAddr = memPtrOne_q;
         effBank = bankSelectBit_q;
      end
      isSfr = effAddr <= `BDMA_SFR_TOP;
   end

   // Special register read mux on the resolved address
   always @*
   begin
      sfrKnown = 1'b1;
      sfrData = `BDMA_RESET_BYTE;
      // Own registers show in both banks; 40H only answers in bank 1, bank 0 reads 00H
      if (effAddr == `BDMA_ADDR_EECTL)
         sfrKnown = !effBank;
      else
         case (effAddr)
            `BDMA_ADDR_IND0: sfrData = `BDMA_RESET_BYTE;
            `BDMA_ADDR_IND1: sfrData = `BDMA_RESET_BYTE;
            `BDMA_ADDR_MP0: sfrData = memPtrZero_q;
            `BDMA_ADDR_MP1: sfrData = memPtrOne_q;
            `BDMA_ADDR_BANK: sfrData = {7'h00, bankSelectBit_q};
            `BDMA_ADDR_ACC: sfrData = accumulator;
            `BDMA_ADDR_PCL: sfrData = pcCurrent[7:0];
            `BDMA_ADDR_TABLE_POINTER_LOW: sfrData = tablePtrLow_q;
            `BDMA_ADDR_TABLE_RESULT_HIGH: sfrData = tableResultHigh_q;
            `BDMA_ADDR_TABLE_POINTER_HIGH: sfrData = tablePtrHigh_q;
            `BDMA_ADDR_UNLOCK: sfrData = optionMapUnlock_q;
            default: sfrKnown = 1'b0;
         endcase
   end

   // Outward RAM strobes and read data selection
   always @*
   begin
      ramEn = (memRead || memWrite) && !isSfr;
      ramWe = memWrite && !isSfr;
      ramAddr = {effBank, effAddr};
      ramWdata = memWdata;
      if (!isSfr)
         memRdata = ramRdata;
      else if (sfrKnown)
         memRdata = sfrData;
      else if (sfrOtherHit)
         memRdata = sfrOtherRdata;
      else
         memRdata = `BDMA_RESET_BYTE;
   end

   // Unlock sequence recognition
   always @*
   begin
      unlockDone = instrCycle && memWrite && isSfr &&
         effAddr == `BDMA_ADDR_UNLOCK &&
         memWdata == `BDMA_UNLOCK_KEY2 &&
         unlockState_q == ST_ARMED;
   end

   always @(posedge clk)
   begin
      if (!rst_n)
         unlockState_q <= ST_IDLE;
      else if (wakeUp)
         unlockState_q <= ST_IDLE;
      else if (instrCycle)
      begin
         case (unlockState_q)
            ST_IDLE:
               if (memWrite && isSfr &&
                  effAddr == `BDMA_ADDR_UNLOCK &&
                  memWdata == `BDMA_UNLOCK_KEY1)
                  unlockState_q <= ST_ARMED;
            ST_ARMED:
               if (memWrite && isSfr &&
                  effAddr == `BDMA_ADDR_UNLOCK &&
                  memWdata == `BDMA_UNLOCK_KEY1)
                  unlockState_q <= ST_ARMED;
               else
                  unlockState_q <= ST_IDLE;
            default: unlockState_q <= ST_IDLE;
         endcase
      end
   end

   bdma_map_timer u_timer
   (
      .clk(clk),
      .rst_n(rst_n),
      .oscPin(lircClk),
      .restart(unlockDone),
      .mapActive(mapActive)
   );

   // Bank bit survives watchdog reset from sleep or idle
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         if (!wdtSleepReset)
            bankSelectBit_q <= 1'b0;
      end
      else if (memWrite && isSfr &&
         effAddr == `BDMA_ADDR_BANK)
         bankSelectBit_q <= memWdata[`BDMA_BANK_BIT];
   end

   // Register writes, accumulator and program counter load
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         memPtrZero_q <= `BDMA_RESET_BYTE;
         memPtrOne_q <= `BDMA_RESET_BYTE;
         tablePtrLow_q <= `BDMA_RESET_BYTE;
         tablePtrHigh_q <= `BDMA_RESET_BYTE;
         optionMapUnlock_q <= `BDMA_RESET_BYTE;
         accumulator <= `BDMA_RESET_BYTE;
         pcLoad <= 1'b0;
         pcLoadValue <= {PC_WIDTH{1'b0}};
         dummyCycle <= 1'b0;
      end
      else
      begin
         pcLoad <= 1'b0;
         dummyCycle <= 1'b0;
         if (aluValid)
            accumulator <= aluResult;
         if (wakeUp)
            optionMapUnlock_q <= `BDMA_RESET_BYTE;
         if (memWrite && isSfr)
            case (effAddr)
               `BDMA_ADDR_MP0: memPtrZero_q <= memWdata;
               `BDMA_ADDR_MP1: memPtrOne_q <= memWdata;
               `BDMA_ADDR_TABLE_POINTER_LOW: tablePtrLow_q <= memWdata;
               `BDMA_ADDR_TABLE_POINTER_HIGH: tablePtrHigh_q <= memWdata;
               `BDMA_ADDR_ACC: accumulator <= memWdata;
               `BDMA_ADDR_UNLOCK:
                  if (!wakeUp)
                     optionMapUnlock_q <= memWdata;
               `BDMA_ADDR_PCL:
               begin
                  pcLoad <= 1'b1;
                  dummyCycle <= 1'b1;
                  pcLoadValue <= {pcCurrent[PC_WIDTH-1:8], memWdata};
               end
               default: pcLoad <= 1'b0;
            endcase
      end
   end

   // Table read addressing and option memory overlay
   assign lastPageBase = {{(PC_WIDTH-8){1'b1}}, 8'h00};
   assign tableAddr = tableLastPage ?
      (lastPageBase | {{(PC_WIDTH-8){1'b0}}, tablePtrLow_q}) :
      {tablePtrHigh_q[PC_WIDTH-9:0], tablePtrLow_q};
   assign inOptWindow = mapActive &&
      (tableAddr[PC_WIDTH-1:8] == {(PC_WIDTH-8){1'b1}}) &&
      (tablePtrLow_q >= `BDMA_OPT_PAGE_BASE);
   assign tableWord = inOptWindow ? optMem[tablePtrLow_q[4:0]] : progRdata;

   always @(posedge clk)
   begin
      if (optWe)
         optMem[optWaddr] <= optWdata;
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         tableResultHigh_q <= `BDMA_RESET_BYTE;
         tableLowData <= `BDMA_RESET_BYTE;
         tableDone <= 1'b0;
      end
      else
      begin
         tableDone <= tableReq;
         if (tableReq)
         begin
            tableResultHigh_q <= tableWord[15:8];
            tableLowData <= tableWord[7:0];
         end
      end
   end
endmodule

// ---- bdma_props.sv ----
// Port assertions for the banked addressing block
`timescale 1ns/1ps
module bdma_props
#(
   parameter PC_WIDTH = 11
)
(
   input logic clk, rst_n, memRead, memWrite, aluValid, ramEn, pcLoad,
   input logic dummyCycle, tableReq, tableDone, sfrOtherHit, mapActive,
   input logic [7:0] memAddr, memWdata, memRdata, aluResult, accumulator,
   input logic [7:0] tableLowData,
   input logic [8:0] ramAddr,
   input logic [PC_WIDTH-1:0] pcLoadValue, pcCurrent,
   input logic [15:0] progRdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_pcl;
      memWrite && memAddr == 8'h06 |=> pcLoad && dummyCycle && pcLoadValue
         == {$past(pcCurrent[PC_WIDTH-1:8]), $past(memWdata)};
   endproperty
   a_pcl: assert property (p_pcl)
      else $error("bad jump");
   property p_acc;
      aluValid |=> accumulator == $past(aluResult);
   endproperty
   a_acc: assert property (p_acc)
      else $error("bad accumulator");
   property p_ind0;
      ramEn && memAddr == 8'h00 |-> !ramAddr[8];
   endproperty
   a_ind0: assert property (p_ind0)
      else $error("port zero left bank 0");
   property p_direct;
      ramEn && memAddr != 8'h00 && memAddr != 8'h02 |->
         ramAddr == {1'h0, memAddr};
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct access left bank 0");
   property p_tbl;
      tableReq && !mapActive |=>
         tableDone && tableLowData == $past(progRdata[7:0]);
   endproperty
   a_tbl: assert property (p_tbl)
      else $error("bad table read");
   property p_unused;
      memRead && memAddr > 8'h09 && memAddr < 8'h80 && memAddr != 8'h3A
         && !sfrOtherHit |-> memRdata == 8'h00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused location not zero");
   property p_unlock;
      $rose(mapActive) |->
         $past(memWrite && memAddr == 8'h3A && memWdata == 8'hAA);
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("mapping without unlock");
   property p_mapmin;
      $rose(mapActive) |=> mapActive [*8];
   endproperty
   a_mapmin: assert property (p_mapmin)
      else $error("mapping ended early");
endmodule

// ---- bdma_mem_model.sv ----
// Data and program memory facing the addressing block
`timescale 1ns/1ps
module bdma_mem_model
(
   input wire clk, ramEn, ramWe,
   input wire [8:0] ramAddr,
   input wire [7:0] ramWdata,
   output logic [7:0] ramRdata,
   input wire [10:0] tableAddr,
   output logic [15:0] progRdata
);
   logic [7:0] mem [0:511];
   logic [7:0] lastVal_q = 8'h00;
   always @(posedge clk)
   begin
      if (ramEn && ramWe)
         mem[ramAddr] <= ramWdata;
      if (ramEn)
         lastVal_q <= mem[ramAddr];
   end
   // Idle bus shows the inverse of the last value
   assign ramRdata = ramEn ? mem[ramAddr] : ~lastVal_q;
   assign progRdata = {tableAddr[7:0] ^ 8'hC3, tableAddr[7:0]};
endmodule

// ---- test_banked_data_memory_addressing.sv ----
// Self-checking bench for the banked addressing block
`timescale 1ns/1ps
module test_banked_data_memory_addressing;
   logic clk, rst_n, wdtSleepReset, wakeUp, lircClk, instrCycle, memRead;
   logic memWrite, aluValid, tableReq, tableLastPage, optWe;
   logic [7:0] memAddr, memWdata, aluResult;
   logic [10:0] pcCurrent;
   logic [4:0] optWaddr;
   logic [15:0] optWdata;
   wire [7:0] memRdata, accumulator, ramWdata, ramRdata, tableLowData;
   wire [8:0] ramAddr;
   wire [10:0] pcLoadValue, tableAddr;
   wire [15:0] progRdata;
   wire ramEn, ramWe, pcLoad, dummyCycle, tableDone, mapActive;
   logic sfrOtherHit;
   logic [7:0] sfrOtherRdata;
   int errorCnt = 0, numChecks = 0, n;
   bdma_core dut (.*);
   bdma_mem_model model (.*);
   always #2 clk = ~clk;
   always #20 lircClk = ~lircClk;
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      numChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, d);
      {memWrite, memRead, instrCycle, memAddr, memWdata} = {3'h5, a, d};
      cyc();
   endtask
   task automatic rd(input logic [7:0] a, exp);
      {memWrite, memRead, instrCycle, memAddr} = {3'h3, a};
      #1 chk("memRdata", memRdata, exp);
      cyc();
   endtask
   task automatic idle();
      {memWrite, memRead, tableReq, aluValid} = 4'h0;
      instrCycle = 1'h1;
      cyc();
   endtask
   task automatic tbl(input logic lp, input logic [10:0] ad,
      input logic [15:0] w);
      {tableReq, tableLastPage, memWrite, memRead} = {1'h1, lp, 2'h0};
      #1 chk("tableAddr", tableAddr, ad);
      cyc();
      tableReq = 1'h0;
      chk("tableDone", tableDone, 1'h1);
      chk("tableLowData", tableLowData, w[7:0]);
      rd(8'h08, w[15:8]);
   endtask
   task automatic rst(input logic w);
      {rst_n, wdtSleepReset} = {1'h0, w};
      repeat (6) cyc();
      rst_n = 1'h1;
      idle();
   endtask
   task automatic endSim();
      $display("Checks %0d errors %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #40000;
      errorCnt++;
      endSim();
   end
   initial
   begin
      {clk, rst_n, wdtSleepReset, wakeUp, lircClk, instrCycle, memRead,
         memWrite, aluValid, tableReq, tableLastPage, memAddr, memWdata,
         aluResult, sfrOtherHit, sfrOtherRdata} = '0;
      {pcCurrent, optWe, optWaddr, optWdata} = {11'h5A3, 22'h0};
      rst(1'h0);
      {optWe, optWaddr, optWdata} = {1'h1, 5'h05, 16'hBEEF};
      rd(8'h04, 8'h00);
      optWe = 1'h0;
      rd(8'h3A, 8'h00);
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'h01);
      wr(8'h01, 8'h85);
      wr(8'h03, 8'h90);
      rd(8'h01, 8'h85);
      rd(8'h03, 8'h90);
      wr(8'h85, 8'h11);
      wr(8'h90, 8'h33);
      wr(8'h02, 8'h22);
      rd(8'h00, 8'h11);
      rd(8'h90, 8'h33);
      rd(8'h02, 8'h22);
      wr(8'h01, 8'h90);
      rd(8'h00, 8'h33);
      wr(8'h03, 8'h04);
      rd(8'h02, 8'h01);
      wr(8'h03, 8'h40);
      {sfrOtherHit, sfrOtherRdata} = {1'h1, 8'hC5};
      rd(8'h02, 8'hC5);
      rd(8'h40, 8'h00);
      sfrOtherHit = 1'h0;
      wr(8'h01, 8'h00);
      wr(8'h00, 8'h5A);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      {memRead, aluValid, aluResult} = {2'h1, 8'h3C};
      cyc();
      aluValid = 1'h0;
      chk("accumulator", accumulator, 8'h3C);
      wr(8'h06, 8'h7E);
      chk("pcLoad", {pcLoad, dummyCycle, pcLoadValue}, {2'h3, 11'h57E});
      wr(8'h07, 8'h10);
      wr(8'h09, 8'h03);
      tbl(1'h0, 11'h310, 16'hD310);
      tbl(1'h1, 11'h710, 16'hD310);
      // Unlock pair sent back to back, nothing in between
      wr(8'h3A, 8'h55);
      wr(8'h3A, 8'hAA);
      idle();
      chk("mapActive", mapActive, 1'h1);
      wr(8'h07, 8'hE5);
      tbl(1'h1, 11'h7E5, 16'hBEEF);
      wr(8'h09, 8'h07);
      tbl(1'h0, 11'h7E5, 16'hBEEF);
      repeat (15) idle();
      wr(8'h3A, 8'h55);
      wr(8'h3A, 8'hAA);
      for (n = 0; mapActive !== 1'h0 && n < 200; n++)
         idle();
      chk("mapCycles", n >= 26 && n <= 46, 16'h1);
      wr(8'h3A, 8'h55);
      idle();
      wr(8'h3A, 8'hAA);
      wr(8'h3A, 8'h55);
      wr(8'h3A, 8'h12);
      wr(8'h3A, 8'hAA);
      idle();
      chk("mapActive", mapActive, 1'h0);
      rd(8'h3A, 8'hAA);
      {wakeUp, memRead} = 2'h2;
      cyc();
      wakeUp = 1'h0;
      rd(8'h3A, 8'h00);
      rst(1'h1);
      rd(8'h04, 8'h01);
      rst(1'h0);
      rd(8'h04, 8'h00);
      endSim();
   end
endmodule
bind bdma_core bdma_props #(.PC_WIDTH(PC_WIDTH)) props (.*);
